// [hw/sli_pkg.sv]
package sli_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_LED    = 8'h08;
  localparam logic [7:0] OFS_IRQ_ST = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MK = 8'h10;

  // Control field positions
  localparam int CTRL_BOOT_OK = 0;
  localparam int CTRL_SLEEP   = 1;
  localparam int CTRL_DUAL    = 2;

  // Interrupt event positions
  localparam int EV_FAULT_SET = 0;
  localparam int EV_SUPPLY_CH = 1;
  localparam int EV_ENC_START = 2;
  localparam int EV_LIMIT_SET = 3;

  // Reset values
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [3:0] MASK_RST = 4'h0;

  // Timing
  localparam int CLK_MHZ          = 200;
  localparam int FLASH_HALF_MS    = 250;
  localparam int ENC_TIMEOUT_MS   = 100;
  localparam int FLASH_HALF_CYC   = FLASH_HALF_MS * CLK_MHZ * 1000;
  localparam int ENC_TIMEOUT_CYC  = ENC_TIMEOUT_MS * CLK_MHZ * 1000;

  typedef enum logic [1:0] {
    SLI_LED_OFF,
    SLI_LED_FLASH,
    SLI_LED_LIT
  } sli_led_mode_t;

  typedef struct packed {
    logic fwd_limit;
    logic rev_limit;
    logic home;
  } sli_limits_t;

  typedef struct packed {
    logic axis_status;
    logic encoder_active;
    logic limit_active;
    logic axis_fault;
  } sli_leds_t;

endpackage

// [hw/sli_status_led.sv]
`timescale 1ns/1ps
module sli_status_led #(
  parameter int FLASH_HALF = sli_pkg::FLASH_HALF_CYC,
  parameter int ENC_TMO    = sli_pkg::ENC_TIMEOUT_CYC,
  parameter int NUM_FAULTS = 8
) (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  input  wire logic                  drive_enable,
  input  wire logic                  external_supply_present,
  input  wire logic [1:0]            enc_a,
  input  wire logic [1:0]            enc_b,
  input  wire sli_pkg::sli_limits_t  limits,
  input  wire logic [NUM_FAULTS-1:0] faults,
  output sli_pkg::sli_leds_t         leds,
  output logic                       irq
);

  // Refused at elaboration: a timer below two counts cannot hold a level
  if (FLASH_HALF < 2 || ENC_TMO < 2 || NUM_FAULTS < 1) begin
    $error("sli_status_led: parameter out of range");
  end
  localparam int NSYNC = 9;
  // Pin synchroniser: three stages; a change counts when stage 2 and 3 agree
  logic [NSYNC-1:0] s1_q, s2_q, s3_q, clean_q;
  logic [NSYNC-1:0] raw;
  assign raw = {drive_enable, external_supply_present, enc_a, enc_b,
                limits.fwd_limit, limits.rev_limit, limits.home};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q    <= '0;
      s2_q    <= '0;
      s3_q    <= '0;
      clean_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < NSYNC; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          clean_q[i] <= s3_q[i];
        end
      end
    end
  end
  logic       drv_en, sup;
  logic [3:0] enc_now;
  logic       lim_any;
  assign drv_en  = clean_q[8];
  assign sup     = clean_q[7];
  assign enc_now = clean_q[6:3];
  assign lim_any = |clean_q[2:0];
  // Fault inputs come from same-clock logic
  logic fault_any;
  assign fault_any = |faults;
  // Control register
  logic [2:0] ctrl_q;
  logic       boot_ok, sleep, dual;
  assign boot_ok = ctrl_q[sli_pkg::CTRL_BOOT_OK];
  assign sleep   = ctrl_q[sli_pkg::CTRL_SLEEP];
  assign dual    = ctrl_q[sli_pkg::CTRL_DUAL];
  logic [31:0] flash_cnt_q;
  logic        flash_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flash_cnt_q <= '0;
      flash_q     <= 1'b0;
    end else if (flash_cnt_q == 32'(FLASH_HALF - 1)) begin
      flash_cnt_q <= '0;
      flash_q     <= ~flash_q;
    end else begin
      flash_cnt_q <= flash_cnt_q + 32'h1;
    end
  end
  // Encoder edge detection
  logic [3:0] enc_prev_q;
  logic [3:0] enc_edges;
  logic       enc_edge;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enc_prev_q <= '0;
    end else begin
      enc_prev_q <= enc_now;
    end
  end
  assign enc_edges = enc_now ^ enc_prev_q;
  // channel 0 always counts, channel 1 only when dual is set; bits 3 and 1 are channel 1, bits 2 and 0 channel 0
  assign enc_edge  = ((enc_edges[3] | enc_edges[1]) & dual) | enc_edges[2] | enc_edges[0];
  logic [31:0] enc_tmo_q;
  logic        enc_act_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enc_tmo_q <= '0;
      enc_act_q <= 1'b0;
    end else if (!sup) begin
      enc_tmo_q <= '0;
      enc_act_q <= 1'b0;
    end else if (enc_edge) begin
      enc_tmo_q <= 32'(ENC_TMO - 1);
      enc_act_q <= 1'b1;
    end else if (enc_tmo_q != 32'h0) begin
      enc_tmo_q <= enc_tmo_q - 32'h1;
    end else begin
      enc_act_q <= 1'b0;
    end
  end
  // Indicator modes
  sli_pkg::sli_led_mode_t axis_mode, enc_mode;
  always_comb begin
    if (sleep || !boot_ok) begin
      axis_mode = sli_pkg::SLI_LED_OFF;
    end else if (drv_en) begin
      axis_mode = sli_pkg::SLI_LED_LIT;
    end else begin
      axis_mode = sli_pkg::SLI_LED_FLASH;
    end
    if (!sup) begin
      enc_mode = sli_pkg::SLI_LED_OFF;
    end else if (enc_act_q) begin
      enc_mode = sli_pkg::SLI_LED_FLASH;
    end else begin
      enc_mode = sli_pkg::SLI_LED_LIT;
    end
  end
  function automatic logic led_level(sli_pkg::sli_led_mode_t m, logic fl);
    case (m)
      sli_pkg::SLI_LED_LIT:   led_level = 1'b1;
      sli_pkg::SLI_LED_FLASH: led_level = fl;
      default:                led_level = 1'b0;
    endcase
  endfunction
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      leds <= '0;
    end else begin
      leds.axis_status    <= led_level(axis_mode, flash_q);
      leds.encoder_active <= led_level(enc_mode, flash_q);
      leds.limit_active   <= sup & lim_any;
      leds.axis_fault     <= fault_any;
    end
  end
  // Interrupt events
  logic       fault_prev_q, sup_prev_q, enc_prev_act_q, lim_prev_q;
  logic [3:0] ev;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault_prev_q   <= 1'b0;
      sup_prev_q     <= 1'b0;
      enc_prev_act_q <= 1'b0;
      lim_prev_q     <= 1'b0;
    end else begin
      fault_prev_q   <= fault_any;
      sup_prev_q     <= sup;
      enc_prev_act_q <= enc_act_q;
      lim_prev_q     <= sup & lim_any;
    end
  end
  always_comb begin
    ev = '0;
    ev[sli_pkg::EV_FAULT_SET] = fault_any & ~fault_prev_q;
    ev[sli_pkg::EV_SUPPLY_CH] = sup ^ sup_prev_q;
    ev[sli_pkg::EV_ENC_START] = enc_act_q & ~enc_prev_act_q;
    ev[sli_pkg::EV_LIMIT_SET] = (sup & lim_any) & ~lim_prev_q;
  end
  // AHB-Lite slave: zero wait states, always OKAY
  logic       ph_valid_q, ph_write_q;
  logic [7:0] ph_addr_q;
  logic       wr_ctrl, wr_ist, wr_msk;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_valid_q <= 1'b0;
      ph_write_q <= 1'b0;
      ph_addr_q  <= '0;
    end else if (hready) begin
      ph_valid_q <= hsel & htrans[1];
      ph_write_q <= hwrite;
      ph_addr_q  <= haddr[7:0];
    end
  end
  assign wr_ctrl = ph_valid_q & ph_write_q & (ph_addr_q == sli_pkg::OFS_CTRL);
  assign wr_ist  = ph_valid_q & ph_write_q & (ph_addr_q == sli_pkg::OFS_IRQ_ST);
  assign wr_msk  = ph_valid_q & ph_write_q & (ph_addr_q == sli_pkg::OFS_IRQ_MK);
  logic [3:0] ist_q, msk_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= sli_pkg::CTRL_RST;
      msk_q  <= sli_pkg::MASK_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= hwdata[2:0];
      end
      if (wr_msk) begin
        msk_q <= hwdata[3:0];
      end
    end
  end
  // New events win over a write-one clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ist_q <= '0;
    end else begin
      ist_q <= (ist_q & ~(wr_ist ? hwdata[3:0] : 4'h0)) | ev;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |((((ist_q & ~(wr_ist ? hwdata[3:0] : 4'h0)) | ev)) & (wr_msk ? hwdata[3:0] : msk_q));
    end
  end
  // Read data registered in address phase so it stands in the data phase
  logic [31:0] rd_d;
  always_comb begin
    rd_d = '0;
    if (haddr[7:0] == sli_pkg::OFS_CTRL) begin
      rd_d = {29'h0, ctrl_q};
    end else if (haddr[7:0] == sli_pkg::OFS_STATUS) begin
      rd_d = {24'h0, fault_any, lim_any, enc_act_q, sup, drv_en, 3'h0};
    end else if (haddr[7:0] == sli_pkg::OFS_LED) begin
      rd_d = {28'h0, leds};
    end else if (haddr[7:0] == sli_pkg::OFS_IRQ_ST) begin
      rd_d = {28'h0, ist_q};
    end else if (haddr[7:0] == sli_pkg::OFS_IRQ_MK) begin
      rd_d = {28'h0, msk_q};
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hrdata    <= (hready & hsel & htrans[1] & ~hwrite) ? rd_d : 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end
  // Assertions
  sequence s_supply_lost;
    !clean_q[7];
  endsequence
  sequence s_led_dark;
    !leds.encoder_active && !leds.limit_active;
  endsequence
  property p_enc_off_unpowered;
    @(posedge hclk) disable iff (!hresetn) s_supply_lost |=> s_led_dark;
  endproperty
  a_enc_off_unpowered: assert property (p_enc_off_unpowered)
    else $error("encoder or limit led lit without supply");
  property p_axis_off;
    @(posedge hclk) disable iff (!hresetn) (sleep || !boot_ok) |=> !leds.axis_status;
  endproperty
  a_axis_off: assert property (p_axis_off)
    else $error("axis led on while asleep or unbooted");
  property p_axis_lit;
    @(posedge hclk) disable iff (!hresetn)
      (!sleep && boot_ok && drv_en) |=> leds.axis_status;
  endproperty
  a_axis_lit: assert property (p_axis_lit)
    else $error("axis led not lit with drive enabled");
  property p_axis_flash;
    @(posedge hclk) disable iff (!hresetn)
      (!sleep && boot_ok && !drv_en) |=> (leds.axis_status == $past(flash_q));
  endproperty
  a_axis_flash: assert property (p_axis_flash)
    else $error("axis led not following flash");
  property p_enc_lit;
    @(posedge hclk) disable iff (!hresetn) (sup && !enc_act_q) |=> leds.encoder_active;
  endproperty
  a_enc_lit: assert property (p_enc_lit)
    else $error("encoder led not lit when idle with supply");
  property p_enc_flash;
    @(posedge hclk) disable iff (!hresetn)
      (sup && enc_act_q) |=> (leds.encoder_active == $past(flash_q));
  endproperty
  a_enc_flash: assert property (p_enc_flash)
    else $error("encoder led not flashing with activity");
  property p_enc_retrig;
    @(posedge hclk) disable iff (!hresetn) (sup && enc_edge) |=> enc_act_q;
  endproperty
  a_enc_retrig: assert property (p_enc_retrig)
    else $error("encoder edge did not start activity");
  property p_limit;
    @(posedge hclk) disable iff (!hresetn) 1'b1 |=> (leds.limit_active == $past(sup && lim_any));
  endproperty
  a_limit: assert property (p_limit)
    else $error("limit led wrong");
  property p_fault;
    @(posedge hclk) disable iff (!hresetn) 1'b1 |=> (leds.axis_fault == $past(fault_any));
  endproperty
  a_fault: assert property (p_fault)
    else $error("fault led wrong");

endmodule

// [sim/sli_led_panel.sv]
`timescale 1ns/1ps
// Operator's view of the panel: counts level changes per LED since clr
module sli_led_panel (
  input  wire logic               hclk,
  input  wire logic               clr,
  input  wire sli_pkg::sli_leds_t leds,
  output logic [3:0][7:0]         tog
);
  logic [3:0] last_q;
  always_ff @(posedge hclk) begin
    last_q <= leds;
    for (int i = 0; i < 4; i++) begin
      if (clr)
        tog[i] <= 8'h00;
      else if (leds[i] != last_q[i] && tog[i] != 8'hFF)
        tog[i] <= tog[i] + 8'h01;
    end
  end
endmodule

// [sim/status_led_indicator_logic_test.sv]
`timescale 1ns/1ps
module status_led_indicator_logic_test;
  localparam int AX = 3, EN = 2, LM = 1, FT = 0;
  logic                 hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic                 clr = 1'b0, drive_enable = 1'b0, external_supply_present = 1'b0;
  logic [31:0]          haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]           htrans = 2'h0, enc_a = 2'h0, enc_b = 2'h0, enc_run = 2'h0;
  logic [2:0]           hsize = 3'h2;
  logic                 hreadyout, hresp, irq;
  sli_pkg::sli_limits_t limits = '0;
  logic [7:0]           faults = 8'h00;
  sli_pkg::sli_leds_t   leds;
  logic [3:0][7:0]      tog;
  int                   enc_per = 12, ecnt = 0, error_cnt = 0, checked = 0, t1;

  always #2.5 hclk = ~hclk;

  sli_status_led #(.FLASH_HALF(4), .ENC_TMO(16), .NUM_FAULTS(8)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .drive_enable(drive_enable), .external_supply_present(external_supply_present),
    .enc_a(enc_a), .enc_b(enc_b), .limits(limits), .faults(faults),
    .leds(leds), .irq(irq));

  sli_led_panel u_panel (.hclk(hclk), .clr(clr), .leds(leds), .tog(tog));

  // Quadrature-like pulses; edge spacing stays below the activity timeout
  always @(posedge hclk) begin
    if (ecnt >= enc_per) begin
      ecnt <= 0;
      enc_a <= enc_a ^ enc_run;
      enc_b <= enc_a;
    end else
      ecnt <= ecnt + 1;
  end

  task complete_run;
    $display("Counts: %0d checks, %0d mismatches", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Waits as long as the slave stalls; only the watchdog ends a hung transfer
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // Settle past sync and timeout, then judge the LED over a 40-cycle window
  task look(input int i, input sli_pkg::sli_led_mode_t m, input string what);
    logic [1:0] got;
    repeat (30) @(posedge hclk);
    clr <= 1'b1;
    @(posedge hclk);
    clr <= 1'b0;
    repeat (40) @(posedge hclk);
    if (tog[i] >= 8'h02)
      got = sli_pkg::SLI_LED_FLASH;
    else
      got = leds[i] ? sli_pkg::SLI_LED_LIT : sli_pkg::SLI_LED_OFF;
    chk(what, {30'h0, m}, {30'h0, got});
  endtask

  task t_regs;
    chk("leds after reset", 32'h0, {28'h0, leds});
    chk("irq after reset", 32'h0, {31'h0, irq});
    ahb(1'b0, sli_pkg::OFS_CTRL, 32'h0);
    chk("ctrl reset", {29'h0, sli_pkg::CTRL_RST}, rd);
    ahb(1'b0, sli_pkg::OFS_IRQ_MK, 32'h0);
    chk("mask reset", {28'h0, sli_pkg::MASK_RST}, rd);
    ahb(1'b1, 8'h14, 32'hFFFFFFFF);
    ahb(1'b0, 8'h14, 32'h0);
    chk("unmapped read", 32'h0, rd);
    ahb(1'b1, sli_pkg::OFS_CTRL, 32'hFFFFFFFF);
    ahb(1'b0, sli_pkg::OFS_CTRL, 32'h0);
    chk("ctrl rw", 32'h7, rd);
    chk("hresp", 32'h0, {31'h0, hresp});
    chk("hreadyout", 32'h1, {31'h0, hreadyout});
    $display("test regs done");
  endtask

  task axis_case(input logic [31:0] c, input logic de, input sli_pkg::sli_led_mode_t m);
    ahb(1'b1, sli_pkg::OFS_CTRL, c);
    drive_enable <= de;
    look(AX, m, "axis led");
  endtask

  task t_axis;
    axis_case(32'h0, 1'b1, sli_pkg::SLI_LED_OFF);
    axis_case(32'h1, 1'b0, sli_pkg::SLI_LED_FLASH);
    axis_case(32'h1, 1'b1, sli_pkg::SLI_LED_LIT);
    axis_case(32'h3, 1'b1, sli_pkg::SLI_LED_OFF);
    axis_case(32'h0, 1'b0, sli_pkg::SLI_LED_OFF);
    $display("test axis done");
  endtask

  task t_enc;
    enc_run <= 2'b01;
    look(EN, sli_pkg::SLI_LED_OFF, "enc no supply");
    external_supply_present <= 1'b1;
    look(EN, sli_pkg::SLI_LED_FLASH, "enc slow pulses");
    t1 = tog[EN];
    enc_per <= 1;
    look(EN, sli_pkg::SLI_LED_FLASH, "enc fast pulses");
    t1 = t1 - tog[EN];
    chk("flash rate", 32'h1, {31'h0, t1 >= -1 && t1 <= 1});
    enc_run <= 2'b00;
    look(EN, sli_pkg::SLI_LED_LIT, "enc idle");
    enc_run <= 2'b10;
    look(EN, sli_pkg::SLI_LED_LIT, "ch1 single");
    ahb(1'b1, sli_pkg::OFS_CTRL, 32'h4);
    look(EN, sli_pkg::SLI_LED_FLASH, "ch1 dual");
    enc_run <= 2'b00;
    ahb(1'b1, sli_pkg::OFS_CTRL, 32'h0);
    $display("test encoder done");
  endtask

  task t_lim;
    for (int i = 0; i < 3; i++) begin
      limits <= 3'h1 << i;
      look(LM, sli_pkg::SLI_LED_LIT, "limit on");
    end
    ahb(1'b0, sli_pkg::OFS_STATUS, 32'h0);
    chk("status reg", 32'h50, rd);
    ahb(1'b0, sli_pkg::OFS_LED, 32'h0);
    chk("led reg", 32'h6, rd);
    limits <= 3'h0;
    look(LM, sli_pkg::SLI_LED_OFF, "limit none");
    limits <= 3'h7;
    external_supply_present <= 1'b0;
    look(LM, sli_pkg::SLI_LED_OFF, "limit no sup");
    limits <= 3'h0;
    $display("test limit done");
  endtask

  task t_fault;
    for (int i = 0; i < 8; i++) begin
      faults <= 8'h01 << i;
      look(FT, sli_pkg::SLI_LED_LIT, "fault on");
    end
    faults <= 8'h00;
    look(FT, sli_pkg::SLI_LED_OFF, "fault none");
    ahb(1'b1, sli_pkg::OFS_IRQ_MK, 32'h1);
    ahb(1'b1, sli_pkg::OFS_IRQ_ST, 32'hF);
    @(posedge hclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    faults <= 8'h04;
    repeat (8) @(posedge hclk);
    chk("irq raised", 32'h1, {31'h0, irq});
    ahb(1'b0, sli_pkg::OFS_IRQ_ST, 32'h0);
    chk("irq status", 32'h1, rd);
    ahb(1'b1, sli_pkg::OFS_IRQ_ST, 32'h1);
    repeat (2) @(posedge hclk);
    chk("irq after w1c", 32'h0, {31'h0, irq});
    ahb(1'b1, sli_pkg::OFS_IRQ_MK, 32'h0);
    faults <= 8'h00;
    repeat (8) @(posedge hclk);
    faults <= 8'h80;
    repeat (8) @(posedge hclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    ahb(1'b0, sli_pkg::OFS_IRQ_ST, 32'h0);
    chk("masked status", 32'h1, rd);
    $display("test fault done");
  endtask

  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_axis();
    t_enc();
    t_lim();
    t_fault();
    complete_run();
  end

  // Whole run needs about 1900 cycles
  initial begin
    repeat (20000) @(posedge hclk);
    error_cnt++;
    complete_run();
  end
endmodule
